// ===== verification/fifo_async_serial_port_tb_top.sv
// Testbench for the serial port
`timescale 1ns/1ps
module fifo_async_serial_port_tb_top;
   logic clk, arst_n, rd, wr, cts_n, rxd, txd, rts_n, tx_irq, wreq;
   logic [4:0] addr;
   logic [31:0] wdata, rdata, q;
   int fail_count = 0;
   int samples_checked = 0;
   logic [7:0] tb[4] = '{8'ha5, 8'h3c, 8'h81, 8'h5a};
   fifo_async_serial_port uut (.clk(clk), .arst_n(arst_n), .avs_address(addr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq),
      .rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n), .tx_irq(tx_irq));
   serial_peer peer (.clk(clk), .txd(txd), .rxd(rxd));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
      addr <= a;
      rd <= !w;
      wr <= w;
      wdata <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wrap_up;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      wrap_up;
   end
   initial
   begin
      {rd, wr, addr, wdata, cts_n, arst_n} = '0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      bus(5'h0, 0, 0);
      chk(q, 32'(serial_port_pkg::RST_FIFO_CONTROL));
      bus(5'h4, 0, 0);
      chk(q, 32'(serial_port_pkg::RST_SERIAL_STATUS));
      bus(5'hc, 0, 0);
      chk(q, 32'(serial_port_pkg::RST_BIT_RATE));
      bus(5'h1c, 1, 32'hffff);
      bus(5'h1c, 0, 0);
      chk(q, 32'h0);
      $display("test registers done");
      bus(5'hc, 1, 0);
      bus(5'h8, 1, 32'h10);
      bus(5'h0, 1, 32'h20);
      bus(5'h18, 1, 32'hb0);
      @(posedge clk);
      chk(tx_irq, 1);
      foreach (tb[i]) bus(5'h10, 1, tb[i]);
      bus(5'h4, 0, 0);
      chk(q[6:5], 2'b01);
      bus(5'h4, 1, 0);
      bus(5'h4, 0, 0);
      chk(q[5], 0);
      chk(tx_irq, 0);
      for (int n = 0; n < 2000 && peer.got.size() < 4; n++) @(posedge clk);
      foreach (tb[i]) chk(peer.got[i], tb[i]);
      repeat (32) @(posedge clk);
      bus(5'h4, 0, 0);
      chk(q[6:5], 2'b11);
      chk(rts_n, 1);
      $display("test transmit done");
      peer.send(8'h96, 1);
      peer.send(8'h0f, 1);
      peer.send(8'hc3, 0);
      repeat (40) @(posedge clk);
      bus(5'h4, 0, 0);
      chk(q[15:8], 8'h01);
      chk(q[1], 1);
      bus(5'h14, 0, 0);
      chk(q[9:0], 10'h096);
      bus(5'h14, 0, 0);
      chk(q[9:0], 10'h00f);
      bus(5'h14, 0, 0);
      chk(q[9:0], 10'h2c3);
      bus(5'h4, 0, 0);
      chk(q[1:0], 2'b00);
      $display("test receive done");
      peer.send(8'h55, 1);
      repeat (40) @(posedge clk);
      bus(5'h0, 1, 32'h22);
      bus(5'h0, 1, 32'h20);
      bus(5'h4, 0, 0);
      chk(q[1], 0);
      bus(5'h18, 1, 32'h90);
      foreach (tb[i]) bus(5'h10, 1, tb[i]);
      bus(5'h0, 1, 32'h24);
      bus(5'h0, 1, 32'h20);
      bus(5'h18, 1, 32'hb0);
      repeat (200) @(posedge clk);
      chk(peer.got.size(), 4);
      bus(5'h4, 0, 0);
      chk(q[5], 1);
      $display("test fifo clear done");
      wrap_up;
   end
endmodule // fifo_async_serial_port_tb_top
bind fifo_async_serial_port serial_port_chk chk_i (.clk(clk), .arst_n(arst_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .txd(txd), .rts_n(rts_n), .tx_irq(tx_irq));

// ===== verification/serial_peer.sv
// Remote serial peer: decodes txd frames, sends frames on rxd
`timescale 1ns/1ps
module serial_peer #(
   parameter int BIT_CLKS = 16
) (
   input wire logic clk,
   input wire logic txd,
   output logic rxd
);
   logic [7:0] got[$];
   logic [7:0] sh;
   initial
   begin
      rxd = 1'b1;
      forever
      begin
         @(negedge txd);
         repeat (BIT_CLKS / 2) @(posedge clk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (BIT_CLKS) @(posedge clk);
            sh[i] = txd;
         end
         repeat (BIT_CLKS) @(posedge clk);
         got.push_back(sh);
      end
   end
   // Stop level given by caller, low makes a framing fault
   task automatic send(input logic [7:0] b, input logic stop);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         rxd <= f[i];
         repeat (BIT_CLKS) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (BIT_CLKS) @(posedge clk);
   endtask
endmodule // serial_peer

// ===== verification/serial_port_chk.sv
// Port-level assertions for the serial port
`timescale 1ns/1ps
module serial_port_chk (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic txd,
   input wire logic rts_n,
   input wire logic tx_irq
);
   logic modem_ff;
   logic irq_en_ff;
   logic tx_en_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Shadow of written enables
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         modem_ff <= 1'b0;
         irq_en_ff <= 1'b0;
         tx_en_ff <= 1'b0;
      end
      else if (avs_write && !avs_waitrequest)
      begin
         if (avs_address == 5'(serial_port_pkg::ADDR_FIFO_CONTROL))
            modem_ff <= avs_writedata[serial_port_pkg::FC_MODEM_BIT];
         if (avs_address == serial_port_pkg::ADDR_SERIAL_CONTROL)
         begin
            irq_en_ff <= avs_writedata[serial_port_pkg::SC_TX_IRQ_BIT];
            tx_en_ff <= avs_writedata[serial_port_pkg::SC_TX_EN_BIT];
         end
      end
   end
   wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer longer than one cycle");
   answer_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
      else $error("answer without request");
   answer_bound_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |-> ##[1:2] !avs_waitrequest) else $error("answer late");
   refused_read_a: assert property (avs_read && !avs_waitrequest && avs_address == 5'h1c
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
   modem_off_a: assert property (!modem_ff && !$past(modem_ff) |-> rts_n)
      else $error("rts active with modem off");
   irq_off_a: assert property (!irq_en_ff && !$past(irq_en_ff) |-> !tx_irq)
      else $error("irq while disabled");
   idle_high_a: assert property (!tx_en_ff && !$past(tx_en_ff) |-> txd)
      else $error("line not idle high");
   start_len_a: assert property ($fell(txd) |-> !txd [*8])
      else $error("low bit too short");
endmodule // serial_port_chk

// ===== verilog/fifo_async_serial_port.sv
// Asynchronous serial port with transmit and receive FIFOs on Avalon-MM
//
// Functional notes
// - Receive threshold 00 means one item
// - Transmit threshold 10 means two items
// - Transmit clear bit empties transmit FIFO
// - Receive clear bit empties receive FIFO
// - Modem off: handshake idle, RTS level ignored
// - Loopback off: lines operate normally
// - Errors upper byte, state lower byte
// - Bits 15-12 count parity faults
// - Bits 11-8 count framing faults
// - Done flag low while sending
// - Low flag set below transmit threshold
// - Full flag low below receive threshold
// - Data-left flag low while receiving
// - Mode bit zero selects asynchronous
// - Frame length, parity, stop from mode
// - Odd/even ignored without parity
// - Source select 00 is undivided clock
// - Eight-bit divisor shared by both directions
// - Low flag cleared only after read one
// - Transmit interrupt while low flag and enable
`timescale 1ns/1ps
module fifo_async_serial_port (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic rxd,
   input wire logic cts_n,
   output logic txd,
   output logic rts_n,
   output logic tx_irq
);
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_START = 2'b01,
      TX_BITS = 2'b11,
      TX_STOP = 2'b10
   } tx_phase_type;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_BITS = 2'b11,
      RX_STOP = 2'b10
   } rx_phase_type;

   typedef struct packed {
      logic [15:0] fifo_control;
      logic [15:0] serial_mode;
      logic [15:0] serial_control;
      logic [7:0] bit_rate;
      logic tx_low_flag;
      logic tx_low_seen;
      logic tx_done_flag;
      logic rx_data_left_flag;
      logic line_break_flag;
      logic rx_fault_flag;
      logic [5:0] pre_cnt;
      logic [7:0] brg_cnt;
      tx_phase_type tx_phase;
      logic [3:0] tx_tick;
      logic [3:0] tx_bit;
      logic [9:0] tx_shift;
      rx_phase_type rx_phase;
      logic [3:0] rx_tick;
      logic [3:0] rx_bit;
      logic [9:0] rx_shift;
      logic [1:0] rxd_sync;
      logic [31:0] rdata;
      logic ack;
      logic txd;
      logic rts_n;
      logic irq;
   } port_state_type;

   port_state_type s_ff;
   port_state_type nxt_s;

   logic tx_push;
   logic tx_pop;
   logic rx_push;
   logic rx_pop;
   logic [7:0] tx_head;
   logic [9:0] rx_head;
   logic [9:0] rx_word;
   logic [4:0] tx_count;
   logic [4:0] rx_count;
   logic [3:0] par_cnt;
   logic [3:0] frm_cnt;
   logic sample_tick;
   logic tx_fifo_low;
   logic rx_fifo_full;
   logic rx_line;

   // Threshold tables for the two-bit selectors
   function automatic logic [4:0] rx_threshold(input logic [1:0] sel);
      unique case (sel)
         2'b00: rx_threshold = 5'h01;
         2'b01: rx_threshold = 5'h04;
         2'b10: rx_threshold = 5'h08;
         2'b11: rx_threshold = 5'h0e;
      endcase
   endfunction

   function automatic logic [4:0] tx_threshold(input logic [1:0] sel);
      unique case (sel)
         2'b00: tx_threshold = 5'h08;
         2'b01: tx_threshold = 5'h04;
         2'b10: tx_threshold = 5'h02;
         2'b11: tx_threshold = 5'h00;
      endcase
   endfunction

   // Count of flagged entries in the receive FIFO
   function automatic logic [3:0] fault_total(input logic [159:0] flat, input int bit_idx,
                                             input logic [4:0] n);
      logic [4:0] acc;
      acc = '0;
      for (int i = 0; i < 16; i++)
      begin
         if (5'(i) < n && flat[i*10+bit_idx])
         begin
            acc = acc + 5'h01;
         end
      end
      fault_total = (acc > 5'h0f) ? 4'hf : acc[3:0];
   endfunction

   serial_fifo #(.WIDTH(8), .DEPTH_LOG2(4)) u_tx_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .clear(s_ff.fifo_control[serial_port_pkg::FC_TX_CLR_BIT]),
      .push(tx_push),
      .push_data(avs_writedata[7:0]),
      .pop(tx_pop),
      .head_data(tx_head),
      .count(tx_count)
   );

   serial_fifo #(.WIDTH(10), .DEPTH_LOG2(4)) u_rx_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .clear(s_ff.fifo_control[serial_port_pkg::FC_RX_CLR_BIT]),
      .push(rx_push),
      .push_data(rx_word),
      .pop(rx_pop),
      .head_data(rx_head),
      .count(rx_count)
   );

   // Fault bits ride beside each data byte; a shadow copy mirrors the FIFO
   logic [159:0] fault_shadow_ff;
   logic [3:0] fault_wr_ff;
   logic [3:0] fault_rd_ff;
   logic [159:0] fault_view;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fault_shadow_ff <= '0;
         fault_wr_ff <= '0;
         fault_rd_ff <= '0;
      end
      else if (s_ff.fifo_control[serial_port_pkg::FC_RX_CLR_BIT])
      begin
         fault_wr_ff <= '0;
         fault_rd_ff <= '0;
      end
      else
      begin
         if (rx_push && rx_count != serial_port_pkg::FIFO_DEPTH_CNT)
         begin
            fault_shadow_ff[fault_wr_ff*10 +: 10] <= rx_word;
            fault_wr_ff <= fault_wr_ff + 4'h1;
         end
         if (rx_pop && rx_count != 5'h00)
         begin
            fault_rd_ff <= fault_rd_ff + 4'h1;
         end
      end
   end

   // Rotate so entry 0 is the oldest item
   always_comb
   begin
      fault_view = (fault_shadow_ff >> (fault_rd_ff * 10)) |
                   (fault_shadow_ff << (160 - fault_rd_ff * 10));
   end

   assign par_cnt = fault_total(fault_view, 8, rx_count);
   assign frm_cnt = fault_total(fault_view, 9, rx_count);

   assign tx_fifo_low = tx_count < tx_threshold(s_ff.fifo_control[5:4]);
   assign rx_fifo_full = rx_count >= rx_threshold(s_ff.fifo_control[7:6]);

   // Loopback feeds transmit line back into the receiver
   assign rx_line = s_ff.fifo_control[serial_port_pkg::FC_LOOP_BIT] ? s_ff.txd
                    : s_ff.rxd_sync[1];

   // Baud source: 00 undivided, then /4, /16, /64
   logic src_tick;
   always_comb
   begin
      unique case (s_ff.serial_mode[1:0])
         2'b00: src_tick = 1'b1;
         2'b01: src_tick = s_ff.pre_cnt[1:0] == 2'b11;
         2'b10: src_tick = s_ff.pre_cnt[3:0] == 4'hf;
         2'b11: src_tick = s_ff.pre_cnt == 6'h3f;
      endcase
   end
   assign sample_tick = src_tick && s_ff.brg_cnt == 8'h00;

   logic bus_req;
   logic tx_fire;
   logic tx_en;
   logic rx_en;
   assign bus_req = (avs_read || avs_write) && !s_ff.ack;
   assign tx_en = s_ff.serial_control[serial_port_pkg::SC_TX_EN_BIT];
   assign rx_en = s_ff.serial_control[serial_port_pkg::SC_RX_EN_BIT];
   assign tx_push = bus_req && avs_write && avs_address == serial_port_pkg::ADDR_TX_FIFO_DATA;
   assign rx_pop = bus_req && avs_read && avs_address == serial_port_pkg::ADDR_RX_FIFO_DATA;
   assign tx_fire = sample_tick && s_ff.tx_tick == serial_port_pkg::OVERSAMPLE_LAST;
   assign tx_pop = tx_fire && s_ff.tx_phase == TX_IDLE && tx_en && tx_count != 5'h00;

   // Received character: 8 or 7 data bits, parity fault in bit 8, framing in bit 9
   logic rx_last_stop;
   logic par_calc;
   logic [3:0] n_data;
   logic [3:0] tx_total;
   assign n_data = s_ff.serial_mode[serial_port_pkg::SM_CHAR_BIT] ? 4'h7 : 4'h8;
   assign tx_total = n_data + {3'b000, s_ff.serial_mode[serial_port_pkg::SM_PARITY_BIT]};
   // Stop sampled at its centre, then idle, so a stop still low is taken as a start edge
   assign rx_last_stop = sample_tick && s_ff.rx_phase == RX_STOP &&
                         s_ff.rx_tick == serial_port_pkg::OVERSAMPLE_LAST;
   always_comb
   begin
      logic [7:0] d;
      // Data in bits 8:1 (8-bit) or 8:2 (7-bit), parity in bit 9
      d = s_ff.serial_mode[serial_port_pkg::SM_CHAR_BIT] ? {1'b0, s_ff.rx_shift[8:2]}
          : s_ff.rx_shift[8:1];
      // Parity even unless odd is selected
      par_calc = (^d) ^ s_ff.rx_shift[9] ^ s_ff.serial_mode[serial_port_pkg::SM_ODD_BIT];
      rx_word = {~rx_line,
                 s_ff.serial_mode[serial_port_pkg::SM_PARITY_BIT] && par_calc, d};
   end
   assign rx_push = rx_last_stop && rx_en;

   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.rxd_sync = {s_ff.rxd_sync[0], rxd};
      nxt_s.ack = 1'b0;
      nxt_s.pre_cnt = s_ff.pre_cnt + 6'h01;
      if (src_tick)
      begin
         nxt_s.brg_cnt = (s_ff.brg_cnt == 8'h00) ? s_ff.bit_rate : s_ff.brg_cnt - 8'h01;
      end
      // Bus access: one wait cycle, answer on the following edge
      if (bus_req)
      begin
         nxt_s.ack = 1'b1;
         nxt_s.rdata = '0;
         if (avs_write)
         begin
            unique case (avs_address)
               5'h00: nxt_s.fifo_control = {5'h00, avs_writedata[10:0]};
               5'h04:
               begin
                  if (!avs_writedata[serial_port_pkg::ST_TX_LOW_BIT] && s_ff.tx_low_seen)
                  begin
                     nxt_s.tx_low_flag = 1'b0;
                     nxt_s.tx_low_seen = 1'b0;
                  end
                  if (!avs_writedata[serial_port_pkg::ST_RX_LEFT_BIT])
                  begin
                     nxt_s.rx_data_left_flag = 1'b0;
                  end
                  if (!avs_writedata[serial_port_pkg::ST_BREAK_BIT])
                  begin
                     nxt_s.line_break_flag = 1'b0;
                  end
                  if (!avs_writedata[serial_port_pkg::ST_FAULT_BIT])
                  begin
                     nxt_s.rx_fault_flag = 1'b0;
                  end
               end
               5'h08: nxt_s.serial_mode = {8'h00, avs_writedata[7:3], 1'b0, avs_writedata[1:0]};
               5'h0c: nxt_s.bit_rate = avs_writedata[7:0];
               5'h18: nxt_s.serial_control = {8'h00, avs_writedata[7:0]};
               default: ;
            endcase
         end
         else
         begin
            unique case (avs_address)
               5'h00: nxt_s.rdata = {16'h0000, s_ff.fifo_control};
               5'h04:
               begin
                  nxt_s.rdata = {16'h0000, par_cnt, frm_cnt, s_ff.rx_fault_flag,
                                 s_ff.tx_done_flag, s_ff.tx_low_flag, s_ff.line_break_flag,
                                 frm_cnt != 4'h0, par_cnt != 4'h0, rx_fifo_full,
                                 s_ff.rx_data_left_flag};
                  nxt_s.tx_low_seen = s_ff.tx_low_flag;
               end
               5'h08: nxt_s.rdata = {16'h0000, s_ff.serial_mode};
               5'h0c: nxt_s.rdata = {24'h000000, s_ff.bit_rate};
               5'h10: nxt_s.rdata = 32'h00000000;
               5'h14: nxt_s.rdata = {22'h000000, rx_head};
               5'h18: nxt_s.rdata = {16'h0000, s_ff.serial_control};
               default: nxt_s.rdata = 32'h00000000;
            endcase
         end
      end
      // Hardware set beats software clear
      if (tx_fifo_low)
      begin
         nxt_s.tx_low_flag = 1'b1;
      end
      if (rx_push && rx_word[9])
      begin
         nxt_s.rx_fault_flag = 1'b1;
      end
      if (rx_push && rx_word[9] && rx_word[7:0] == 8'h00)
      begin
         nxt_s.line_break_flag = 1'b1;
      end
      // Transmitter, 16 ticks per bit, asynchronous only
      if (sample_tick)
      begin
         nxt_s.tx_tick = s_ff.tx_tick + 4'h1;
      end
      if (tx_fire && !s_ff.serial_mode[serial_port_pkg::SM_SYNC_BIT])
      begin
         unique case (s_ff.tx_phase)
            TX_IDLE:
            begin
               nxt_s.txd = 1'b1;
               if (tx_pop)
               begin
                  nxt_s.tx_phase = TX_START;
                  nxt_s.tx_done_flag = 1'b0;
                  nxt_s.tx_shift = {1'b0,
                                    ^tx_head[7:0] ^ ^(s_ff.serial_mode[6] ? tx_head[7] : 1'b0)
                                    ^ s_ff.serial_mode[serial_port_pkg::SM_ODD_BIT], tx_head};
                  if (s_ff.serial_mode[serial_port_pkg::SM_CHAR_BIT])
                  begin
                     nxt_s.tx_shift[7] = nxt_s.tx_shift[8];
                  end
               end
               else
               begin
                  nxt_s.tx_done_flag = 1'b1;
               end
            end
            TX_START:
            begin
               nxt_s.txd = 1'b0;
               nxt_s.tx_bit = 4'h0;
               nxt_s.tx_phase = TX_BITS;
            end
            TX_BITS:
            begin
               nxt_s.txd = s_ff.tx_shift[s_ff.tx_bit];
               nxt_s.tx_bit = s_ff.tx_bit + 4'h1;
               if (s_ff.tx_bit + 4'h1 == tx_total)
               begin
                  nxt_s.tx_phase = TX_STOP;
                  nxt_s.tx_bit = 4'h0;
               end
            end
            TX_STOP:
            begin
               nxt_s.txd = 1'b1;
               nxt_s.tx_bit = s_ff.tx_bit + 4'h1;
               if (s_ff.tx_bit == {3'b000, s_ff.serial_mode[serial_port_pkg::SM_STOP_BIT]})
               begin
                  nxt_s.tx_phase = TX_IDLE;
               end
            end
         endcase
      end
      // Queued data counts as a transmission under way
      if (tx_push)
      begin
         nxt_s.tx_done_flag = 1'b0;
      end
      // Receiver samples bit centres
      if (sample_tick && rx_en)
      begin
         nxt_s.rx_tick = s_ff.rx_tick + 4'h1;
         unique case (s_ff.rx_phase)
            RX_IDLE:
            begin
               nxt_s.rx_tick = 4'h0;
               if (!rx_line)
               begin
                  nxt_s.rx_phase = RX_START;
                  nxt_s.rx_data_left_flag = 1'b0;
               end
            end
            RX_START:
            begin
               if (s_ff.rx_tick == serial_port_pkg::OVERSAMPLE_MID)
               begin
                  nxt_s.rx_phase = rx_line ? RX_IDLE : RX_BITS;
                  nxt_s.rx_bit = 4'h0;
                  nxt_s.rx_tick = 4'h0;
               end
            end
            RX_BITS:
            begin
               if (s_ff.rx_tick == serial_port_pkg::OVERSAMPLE_LAST)
               begin
                  nxt_s.rx_shift = {rx_line, s_ff.rx_shift[9:1]};
                  nxt_s.rx_bit = s_ff.rx_bit + 4'h1;
                  if (s_ff.rx_bit + 4'h1 == tx_total)
                  begin
                     nxt_s.rx_phase = RX_STOP;
                     if (!s_ff.serial_mode[serial_port_pkg::SM_PARITY_BIT])
                     begin
                        nxt_s.rx_shift = {1'b0, rx_line, s_ff.rx_shift[9:2]};
                     end
                  end
               end
            end
            RX_STOP:
            begin
               if (s_ff.rx_tick == serial_port_pkg::OVERSAMPLE_LAST)
               begin
                  nxt_s.rx_phase = RX_IDLE;
               end
            end
         endcase
      end
      if (rx_count == 5'h00 && s_ff.rx_phase == RX_IDLE)
      begin
         nxt_s.rx_data_left_flag = 1'b0;
      end
      nxt_s.rts_n = !(s_ff.fifo_control[serial_port_pkg::FC_MODEM_BIT] &&
                      rx_count < {2'b00, s_ff.fifo_control[10:8]} + 5'h08);
      nxt_s.irq = s_ff.serial_control[serial_port_pkg::SC_TX_IRQ_BIT] && nxt_s.tx_low_flag;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_ff <= '0;
         s_ff.fifo_control <= serial_port_pkg::RST_FIFO_CONTROL;
         s_ff.serial_mode <= serial_port_pkg::RST_SERIAL_MODE;
         s_ff.serial_control <= serial_port_pkg::RST_SERIAL_CONTROL;
         s_ff.bit_rate <= serial_port_pkg::RST_BIT_RATE;
         s_ff.tx_low_flag <= 1'b1;
         s_ff.tx_done_flag <= 1'b1;
         s_ff.rxd_sync <= 2'b11;
         s_ff.txd <= 1'b1;
         s_ff.rts_n <= 1'b1;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign avs_readdata = s_ff.rdata;
   assign avs_waitrequest = !s_ff.ack;
   assign txd = s_ff.txd;
   assign rts_n = s_ff.rts_n;
   assign tx_irq = s_ff.irq;
endmodule // fifo_async_serial_port

// ===== verilog/serial_fifo.sv
// Sixteen-entry FIFO of WIDTH-bit words with synchronous clear and fill count
`timescale 1ns/1ps
module serial_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH_LOG2 = 4
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clear,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   output logic [WIDTH-1:0] head_data,
   output logic [DEPTH_LOG2:0] count
);
   typedef struct packed {
      logic [DEPTH_LOG2-1:0] wr_ptr;
      logic [DEPTH_LOG2-1:0] rd_ptr;
      logic [DEPTH_LOG2:0] cnt;
   } fifo_state_type;

   logic [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];
   fifo_state_type state_ff;
   fifo_state_type nxt_state;
   logic do_push;
   logic do_pop;

   assign do_push = push && !clear && (state_ff.cnt != (DEPTH_LOG2+1)'(1 << DEPTH_LOG2));
   assign do_pop = pop && !clear && (state_ff.cnt != '0);
   assign head_data = mem[state_ff.rd_ptr];
   assign count = state_ff.cnt;

   always_comb
   begin
      nxt_state = state_ff;
      if (clear)
      begin
         nxt_state = '0;
      end
      else
      begin
         if (do_push)
         begin
            nxt_state.wr_ptr = state_ff.wr_ptr + 1'b1;
         end
         if (do_pop)
         begin
            nxt_state.rd_ptr = state_ff.rd_ptr + 1'b1;
         end
         nxt_state.cnt = state_ff.cnt + (DEPTH_LOG2+1)'(do_push) - (DEPTH_LOG2+1)'(do_pop);
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk)
   begin
      if (do_push)
      begin
         mem[state_ff.wr_ptr] <= push_data;
      end
   end
endmodule // serial_fifo

// ===== verilog/serial_port_pkg.sv
// Register map, field positions and reset values of the serial port
package serial_port_pkg;
   // Register byte addresses (word aligned)
   localparam logic [3:0] ADDR_FIFO_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_SERIAL_STATUS = 4'h4;
   localparam logic [3:0] ADDR_SERIAL_MODE = 4'h8;
   localparam logic [3:0] ADDR_BIT_RATE = 4'hc;
   localparam logic [4:0] ADDR_TX_FIFO_DATA = 5'h10;
   localparam logic [4:0] ADDR_RX_FIFO_DATA = 5'h14;
   localparam logic [4:0] ADDR_SERIAL_CONTROL = 5'h18;
   // fifo_control fields
   localparam int FC_RTS_LO = 8;
   localparam int FC_RX_THR_LO = 6;
   localparam int FC_TX_THR_LO = 4;
   localparam int FC_MODEM_BIT = 3;
   localparam int FC_TX_CLR_BIT = 2;
   localparam int FC_RX_CLR_BIT = 1;
   localparam int FC_LOOP_BIT = 0;
   // serial_status fields
   localparam int ST_PAR_CNT_LO = 12;
   localparam int ST_FRM_CNT_LO = 8;
   localparam int ST_FAULT_BIT = 7;
   localparam int ST_TX_DONE_BIT = 6;
   localparam int ST_TX_LOW_BIT = 5;
   localparam int ST_BREAK_BIT = 4;
   localparam int ST_FRM_BIT = 3;
   localparam int ST_PAR_BIT = 2;
   localparam int ST_RX_FULL_BIT = 1;
   localparam int ST_RX_LEFT_BIT = 0;
   // serial_mode fields
   localparam int SM_SYNC_BIT = 7;
   localparam int SM_CHAR_BIT = 6;
   localparam int SM_PARITY_BIT = 5;
   localparam int SM_ODD_BIT = 4;
   localparam int SM_STOP_BIT = 3;
   localparam int SM_SRC_LO = 0;
   // serial_control fields
   localparam int SC_TX_IRQ_BIT = 7;
   localparam int SC_TX_EN_BIT = 5;
   localparam int SC_RX_EN_BIT = 4;
   // Reset values
   localparam logic [15:0] RST_FIFO_CONTROL = 16'h0000;
   localparam logic [15:0] RST_SERIAL_STATUS = 16'h0060;
   localparam logic [15:0] RST_SERIAL_MODE = 16'h0000;
   localparam logic [7:0] RST_BIT_RATE = 8'hff;
   localparam logic [15:0] RST_SERIAL_CONTROL = 16'h0000;
   // Sixteen samples per bit
   localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
   localparam logic [3:0] OVERSAMPLE_MID = 4'h7;
   localparam logic [4:0] FIFO_DEPTH_CNT = 5'h10;
endpackage
